// ### rtl/prf_defs.vh
// How it works
// (R1) Status bits 7:6 carry header version, always 00 for version one.
// (R2) Status bit 4 set when the averaged MER field is valid.
// (R3) Status bits 3:2 say which per-section reports follow.
// (R4) Status bit 1 set when the frequency error field is valid.
// (R5) Status bit 0 set when a vendor field is appended.
// (R6) An 8-bit probe symbol count follows the status byte.
// (R7) An 8-bit section count gives entries per multi-section report.
// (R8) An 8-bit coefficient set count fixes the number of sets.
// (R9) Header carries the 32-bit first probe map element.
// (R10) Header ends with the 32-bit start minislot.
// (R11) Payload opens with the 8-bit averaged MER.
// (R12) Power error is signed 8 bits, quarter-dB, received minus target.
// (R13) Frequency error is signed 16 bits, one hertz per bit.
// (R14) One signed 32-bit timing error matching the coefficients.
// (R15) Per-section timing errors, 32 bits each, section-count entries.
// (R16) Per-section MERs, unsigned 8 bits each, section-count entries.
// (R17) Coefficients may come in several sets, 32*(2+H-L) bits each.
// (R18) Each set opens with a 16-bit lowest index word, index bits 0-11.
// (R19) Then a 16-bit highest index word with the same layout.
// (R20) Coefficients low to high, 2-byte real then 2-byte imaginary.
// (R21) Three-byte vendor identifier only when the vendor bit is set.
// (R22) One-byte vendor length follows it and never exceeds 32.
// (R23) Vendor content follows, exactly as many bytes as the length.
// (R24) One report unit per packet; units never share a packet.
// (R25) Reserved status bit 5 and upper index bits are driven zero.
// (R26) Payload fields in fixed order; absent fields take no bytes.
`ifndef PRF_DEFS_VH
`define PRF_DEFS_VH

// =======================================
// Register byte offsets
`define PRF_CTRL_OFS      8'h00
`define PRF_STAT_OFS      8'h04
`define PRF_COUNT_OFS     8'h08
`define PRF_PMAP_OFS      8'h0C
`define PRF_MSLOT_OFS     8'h10
`define PRF_MEAS_OFS      8'h14
`define PRF_TIMING_OFS    8'h18
`define PRF_VENDOR_OFS    8'h1C
`define PRF_MADDR_OFS     8'h20
`define PRF_MDATA_OFS     8'h24

// =======================================
// Field positions and constants
`define PRF_CTRL_START    8
`define PRF_STAT_LENERR   1
`define PRF_VERSION       2'h0
`define PRF_FIX_BYTES     16'h0014
`define PRF_VHDR_BYTES    16'h0004
`define PRF_VLEN_MAX      8'h20
`define PRF_IDX_MASK      8'h0F

`endif

// ### rtl/prf_framer.v
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "prf_defs.vh"

// ==================================================
// Probe report framer
//
// Builds one report unit as a byte stream, most significant byte first.
// Software loads the fixed fields over the register bus, fills the
// report memory with the variable parts, and then writes the start bit.
//
// Stream order of one report unit:
//    Status byte, version in the top two bits, reserved bit zero
//    Probe symbol count
//    Section count
//    Coefficient set count
//    First probe map element, four bytes
//    Start minislot, four bytes
//    Averaged MER
//    Power error
//    Frequency error, two bytes
//    Timing error, four bytes
//    Per-section timing errors, four bytes each, when asked for
//    Per-section MERs, one byte each, when asked for
//    Coefficient sets, each with its two index words first
//    Vendor identifier, length byte and content, when the bit is set
//
// Report memory layout, read from word zero for every report:
//    Section timing words, one per section
//    Section MER words, four MERs to a word, first MER on top
//    Per set: index word, then one word per coefficient
//    Vendor content words, first byte on top
//
// Each phase starts on a word boundary, so a phase that ends inside a
// word skips the rest of that word before the next phase begins.
//
// Control low bits are copied straight into the status byte:
//    bit 4    averaged MER valid
//    bits 3:2 which per-section reports follow
//    bit 1    frequency error valid
//    bit 0    vendor field present
//
// Hazards and limits:
//    Stored data is not copied at start; configuration writes are
//    refused with an error while a report is in flight instead;
//    control writes are dropped then without an error.
//    A highest index below the lowest one gives a wrong set length;
//    software must not load such a set.
//    A start with the vendor bit set and a length above the limit is
//    refused and raises the sticky length error.
//    Every phase boundary costs one idle cycle, even an empty phase.
//    The stream stalls for as long as the receiver holds ready low.
//
// Bus timing:
//    Ready is tied high, so every access completes in one cycle.
//    Read data is captured in the setup phase and holds until the
//    next setup phase.

module prf_framer #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input  wire        clock,
   input  wire        rst,
   // APB slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Report byte stream
   output reg         outValid,
   output reg  [7:0]  outData,
   output reg         outLast,
   input  wire        outReady
);

   localparam DEPTH = 1 << ADDR_W;

   // ==================================================
   // State codes, one-hot
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_FIX  = 7'h02;
   localparam [6:0] ST_SECT = 7'h04;
   localparam [6:0] ST_SMER = 7'h08;
   localparam [6:0] ST_COEF = 7'h10;
   localparam [6:0] ST_VHDR = 7'h20;
   localparam [6:0] ST_VDAT = 7'h40;

   // ==================================================
   // Registers
   reg [4:0]        flags_reg;
   reg [7:0]        numSym_reg;
   reg [7:0]        sectCnt_reg;
   reg [7:0]        setCnt_reg;
   reg [31:0]       pmap_reg;
   reg [31:0]       mslot_reg;
   reg [31:0]       meas_reg;
   reg [31:0]       timing_reg;
   reg [31:0]       vendor_reg;
   reg [ADDR_W-1:0] memPtr_reg;
   reg              lenErr_reg;
   reg [7:0]        frames_reg;
   reg [31:0]       mem [0:DEPTH-1];

   reg [6:0]        state_reg;
   reg [15:0]       bytesLeft_reg;
   reg [1:0]        byteIdx_reg;
   reg [ADDR_W-1:0] rdPtr_reg;
   reg [7:0]        setsLeft_reg;
   reg              setHdr_reg;

   // ==================================================
   // APB decode
   wire busy    = (state_reg != ST_IDLE);
   wire access  = psel & penable;
   wire wrAcc   = access & pwrite;
   wire mapped  = (paddr[1:0] == 2'h0) && (paddr <= `PRF_MDATA_OFS);
   wire wrBusy  = busy && (paddr != `PRF_STAT_OFS) && (paddr != `PRF_CTRL_OFS);
   wire wrOk    = wrAcc & mapped & ~wrBusy;
   wire startWr = wrOk && (paddr == `PRF_CTRL_OFS) && pwdata[`PRF_CTRL_START] && !busy;
   wire vendOn  = flags_reg[0];
   wire [7:0] vendLen = vendor_reg[7:0];
   // Length check uses the vendor bit being written with the start
   wire lenBad  = pwdata[0] && (vendLen > `PRF_VLEN_MAX);
   wire goFrame = startWr && !lenBad;

   assign pready  = 1'b1;
   assign pslverr = access & (~mapped | (pwrite & wrBusy));

   // Read data captured in the setup phase
   always @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            `PRF_CTRL_OFS:   prdata <= {27'h0000000, flags_reg};
            `PRF_STAT_OFS:   prdata <= {16'h0000, frames_reg, 6'h00, lenErr_reg, busy};
            `PRF_COUNT_OFS:  prdata <= {8'h00, setCnt_reg, sectCnt_reg, numSym_reg};
            `PRF_PMAP_OFS:   prdata <= pmap_reg;
            `PRF_MSLOT_OFS:  prdata <= mslot_reg;
            `PRF_MEAS_OFS:   prdata <= meas_reg;
            `PRF_TIMING_OFS: prdata <= timing_reg;
            `PRF_VENDOR_OFS: prdata <= vendor_reg;
            `PRF_MADDR_OFS:  prdata <= {{(32-ADDR_W){1'b0}}, memPtr_reg};
            default:         prdata <= 32'h00000000;
         endcase
      end
   end

   // Configuration writes, dropped while a report is in flight
   always @(posedge clock) begin
      if (rst) begin
         flags_reg   <= 5'h00;
         numSym_reg  <= 8'h00;
         sectCnt_reg <= 8'h00;
         setCnt_reg  <= 8'h00;
         pmap_reg    <= 32'h00000000;
         mslot_reg   <= 32'h00000000;
         meas_reg    <= 32'h00000000;
         timing_reg  <= 32'h00000000;
         vendor_reg  <= 32'h00000000;
         memPtr_reg  <= {ADDR_W{1'b0}};
      end else if (wrOk) begin
         case (paddr)
            `PRF_CTRL_OFS:   if (!busy) flags_reg <= pwdata[4:0];
            `PRF_COUNT_OFS: begin
               numSym_reg  <= pwdata[7:0];    // R6
               sectCnt_reg <= pwdata[15:8];   // R7
               setCnt_reg  <= pwdata[23:16];  // R8
            end
            `PRF_PMAP_OFS:   pmap_reg   <= pwdata;
            `PRF_MSLOT_OFS:  mslot_reg  <= pwdata;
            `PRF_MEAS_OFS:   meas_reg   <= pwdata;
            `PRF_TIMING_OFS: timing_reg <= pwdata;
            `PRF_VENDOR_OFS: vendor_reg <= pwdata;
            `PRF_MADDR_OFS:  memPtr_reg <= pwdata[ADDR_W-1:0];
            `PRF_MDATA_OFS:  memPtr_reg <= memPtr_reg + 1'b1;
            default:         memPtr_reg <= memPtr_reg;
         endcase
      end
   end

   // Measurement memory fill
   always @(posedge clock) begin
      if (wrOk && (paddr == `PRF_MDATA_OFS)) begin
         mem[memPtr_reg] <= pwdata;
      end
   end

   // Length error flag, set beats the write-one clear
   always @(posedge clock) begin
      if (rst) begin
         lenErr_reg <= 1'b0;
      end else if (startWr && lenBad) begin
         lenErr_reg <= 1'b1;                   // R22
      end else if (wrAcc && (paddr == `PRF_STAT_OFS) && pwdata[`PRF_STAT_LENERR]) begin
         lenErr_reg <= 1'b0;
      end
   end

   // ==================================================
   // Byte sources
   // Section mode sits at status bits 3:2
   wire [1:0]  secMode = flags_reg[3:2];
   wire        sectT   = secMode[0] && (sectCnt_reg != 8'h00);
   wire        sectM   = secMode[1] && (sectCnt_reg != 8'h00);
   wire [7:0]  statusByte = {`PRF_VERSION, 1'b0, flags_reg};   // R1 R2 R3 R4 R5 R25
   wire [159:0] fixVec = {statusByte, numSym_reg, sectCnt_reg, setCnt_reg,  // R6 R7 R8
                          pmap_reg, mslot_reg,                              // R9 R10
                          meas_reg[7:0], meas_reg[15:8], meas_reg[31:16],
                          timing_reg};                           // R11 R12 R13 R14
   wire [159:0] fixSh  = fixVec >> {bytesLeft_reg[4:0] - 5'h01, 3'b000};
   wire [31:0]  vendSh = vendor_reg >> {bytesLeft_reg[1:0] - 2'h1, 3'b000};   // R21 R22
   wire [31:0]  memWord = mem[rdPtr_reg];
   wire [31:0]  memSh   = memWord >> {~byteIdx_reg, 3'b000};
   wire [12:0]  setWords = {1'b0, memWord[11:0]} - {1'b0, memWord[27:16]} + 13'h0002;  // R17
   wire [7:0]   memByte  = (setHdr_reg && !byteIdx_reg[0]) ?
                           (memSh[7:0] & `PRF_IDX_MASK) : memSh[7:0];   // R18 R19 R25

   // Current byte, and whether any byte follows the current phase
   reg [7:0] curByte;
   reg       moreAfter;
   always @* begin
      curByte   = 8'h00;
      moreAfter = 1'b0;
      case (state_reg)
         ST_FIX: begin
            curByte   = fixSh[7:0];
            moreAfter = sectT | sectM | (setCnt_reg != 8'h00) | vendOn;
         end
         ST_SECT: begin
            curByte   = memByte;
            moreAfter = sectM | (setCnt_reg != 8'h00) | vendOn;
         end
         ST_SMER: begin
            curByte   = memByte;
            moreAfter = (setCnt_reg != 8'h00) | vendOn;
         end
         ST_COEF: begin
            curByte   = memByte;
            moreAfter = (setsLeft_reg != 8'h00) | vendOn;
         end
         ST_VHDR: begin
            curByte   = vendSh[7:0];
            moreAfter = (vendLen != 8'h00);
         end
         ST_VDAT: begin
            curByte   = memByte;
            moreAfter = 1'b0;
         end
         default: begin
            curByte   = 8'h00;
            moreAfter = 1'b0;
         end
      endcase
   end

   wire canOut   = !outValid || outReady;
   wire byteSt   = (state_reg != ST_IDLE);
   wire memPhase = (state_reg == ST_SECT) || (state_reg == ST_SMER) ||
                   (state_reg == ST_COEF) || (state_reg == ST_VDAT);
   wire emit     = byteSt && (bytesLeft_reg != 16'h0000) && canOut;
   wire phaseEnd = byteSt && (bytesLeft_reg == 16'h0000);

   // ==================================================
   // Output register
   always @(posedge clock) begin
      if (rst) begin
         outValid <= 1'b0;
         outData  <= 8'h00;
         outLast  <= 1'b0;
      end else if (emit) begin
         outValid <= 1'b1;
         outData  <= curByte;
         outLast  <= (bytesLeft_reg == 16'h0001) && !moreAfter;   // R24
      end else if (outReady) begin
         outValid <= 1'b0;
         outLast  <= 1'b0;
      end
   end

   // ==================================================
   // Framing sequencer
   //
   // Byte phases, in order:
   //    Fixed fields, twenty bytes
   //    Section timings, when mode bit 0 is set and sections exist
   //    Section MERs, when mode bit 1 is set and sections exist
   //    Coefficient sets, one pass per set, length from its index word
   //    Vendor header, then vendor content
   //
   // While a byte is emitted the sequencer only counts down; the phase
   // change happens in the cycle after the count reaches zero.
   //
   // Memory phases walk a word byte by byte and move to the next word
   // after its fourth byte or after the last byte of the phase.
   //
   // The completed report count advances once per report unit, on
   // the step back to idle.
   always @(posedge clock) begin
      if (rst) begin
         state_reg     <= ST_IDLE;
         bytesLeft_reg <= 16'h0000;
         byteIdx_reg   <= 2'h0;
         rdPtr_reg     <= {ADDR_W{1'b0}};
         setsLeft_reg  <= 8'h00;
         setHdr_reg    <= 1'b0;
         frames_reg    <= 8'h00;
      end else if (emit) begin
         // Step through the phase; memory phases walk words big-endian
         bytesLeft_reg <= bytesLeft_reg - 16'h0001;
         if (memPhase) begin
            if ((byteIdx_reg == 2'h3) || (bytesLeft_reg == 16'h0001)) begin
               byteIdx_reg <= 2'h0;
               rdPtr_reg   <= rdPtr_reg + 1'b1;
               setHdr_reg  <= 1'b0;
            end else begin
               byteIdx_reg <= byteIdx_reg + 2'h1;
            end
         end
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (goFrame) begin
                  state_reg     <= ST_FIX;
                  bytesLeft_reg <= `PRF_FIX_BYTES;
                  rdPtr_reg     <= {ADDR_W{1'b0}};
                  byteIdx_reg   <= 2'h0;
                  setsLeft_reg  <= setCnt_reg;
               end
            end
            ST_FIX: begin
               if (phaseEnd) begin
                  state_reg     <= ST_SECT;
                  bytesLeft_reg <= sectT ? {6'h00, sectCnt_reg, 2'h0} : 16'h0000;   // R15
               end
            end
            ST_SECT: begin
               if (phaseEnd) begin
                  state_reg     <= ST_SMER;
                  bytesLeft_reg <= sectM ? {8'h00, sectCnt_reg} : 16'h0000;   // R16
               end
            end
            ST_SMER: begin
               if (phaseEnd) begin
                  state_reg <= ST_COEF;                                      // R26
               end
            end
            ST_COEF: begin
               if (phaseEnd && (setsLeft_reg != 8'h00)) begin
                  bytesLeft_reg <= {1'b0, setWords, 2'h0};                  // R17 R20
                  setsLeft_reg  <= setsLeft_reg - 8'h01;
                  setHdr_reg    <= 1'b1;
               end else if (phaseEnd) begin
                  state_reg     <= vendOn ? ST_VHDR : ST_IDLE;              // R21
                  bytesLeft_reg <= vendOn ? `PRF_VHDR_BYTES : 16'h0000;
                  if (!vendOn) begin
                     frames_reg <= frames_reg + 8'h01;
                  end
               end
            end
            ST_VHDR: begin
               if (phaseEnd) begin
                  state_reg     <= ST_VDAT;
                  bytesLeft_reg <= {8'h00, vendLen};                         // R23
               end
            end
            ST_VDAT: begin
               if (phaseEnd) begin
                  state_reg  <= ST_IDLE;
                  frames_reg <= frames_reg + 8'h01;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ### sim/prf_framer_checker.sv
`timescale 1ns/100ps
// ==========
// Report stream checker
module prf_framer_checker (
   // Clock and reset
   input wire        clock,
   input wire        rst,
   // APB
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Report stream
   input wire        outValid,
   input wire [7:0]  outData,
   input wire        outLast,
   input wire        outReady
);
   reg        idleReg;
   reg [15:0] idxReg;
   reg [7:0]  statReg;
   reg [7:0]  setsReg;
   reg [31:0] cntReg;
   wire       take = outValid && outReady;
   wire       acc = psel && penable && pwrite;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Byte position inside the current report
   always @(posedge clock) begin
      if (rst) begin
         idleReg <= 1'b1;
         idxReg <= 16'h0000;
      end else if (take) begin
         idleReg <= outLast;
         idxReg <= outLast ? 16'h0000 : idxReg + 16'h0001;
      end
   end
   // Status, set count and programmed counts
   always @(posedge clock) begin
      if (take && idxReg == 16'h0000) statReg <= outData;
      if (take && idxReg == 16'h0003) setsReg <= outData;
      if (acc && paddr == 8'h08 && idleReg && !outValid) cntReg <= pwdata;
   end
   ver_zero_a: assert property (outValid && idleReg |-> outData[7:5] == 3'h0)
      else $error("status version or reserved bit not zero");
   status_cfg_a: assert property (
      acc && paddr == 8'h00 && pwdata[8] && !pwdata[0] && idleReg && !outValid
      |-> ##2 outValid && outData[4:0] == $past(pwdata[4:0], 2))
      else $error("status byte does not follow control");
   sym_cnt_a: assert property (outValid && idxReg == 16'h0001 |-> outData == cntReg[7:0])
      else $error("symbol count byte wrong");
   sect_cnt_a: assert property (outValid && idxReg == 16'h0002 |-> outData == cntReg[15:8])
      else $error("section count byte wrong");
   set_cnt_a: assert property (outValid && idxReg == 16'h0003 |-> outData == cntReg[23:16])
      else $error("set count byte wrong");
   byte_hold_a: assert property (
      outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast))
      else $error("stalled byte changed");
   hdr_run_a: assert property (take && !outLast && idxReg < 16'h0013 |=> outValid)
      else $error("gap inside fixed fields");
   min_len_a: assert property (outValid && outLast |-> idxReg >= 16'h0013)
      else $error("report ended too early");
   plain_end_a: assert property (
      outValid && idxReg == 16'h0013 && statReg[3:2] == 2'h0 && !statReg[0]
      && setsReg == 8'h00 |-> outLast)
      else $error("plain report not ended after fixed fields");
endmodule

// ### sim/prf_sink_model.sv
`timescale 1ns/100ps
// ==========
// Far-end report parser stand-in
module prf_sink_model (
   // Clock and reset
   input wire       clock,
   input wire       rst,
   // Control
   input wire       slow,
   // Report stream
   input wire       outValid,
   input wire [7:0] outData,
   input wire       outLast,
   output reg       outReady,
   // Received byte
   output reg       got,
   output reg [8:0] gotByte
);
   reg [7:0] lfsrReg;
   // Take bytes, stalling pseudo-randomly when slow
   always @(posedge clock) begin
      if (rst) begin
         lfsrReg <= 8'hA5;
         outReady <= 1'b0;
         got <= 1'b0;
         gotByte <= 9'h000;
      end else begin
         lfsrReg <= {lfsrReg[6:0], lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
         outReady <= !slow || lfsrReg[0];
         got <= outValid && outReady;
         gotByte <= {outLast, outData};
      end
   end
endmodule

// ### sim/test_probe_report_framer.sv
`timescale 1ns/100ps
// ==========
// Framer bench
module test_probe_report_framer;
   reg         clock;
   reg         rst;
   reg  [7:0]  paddr;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        outValid;
   wire [7:0]  outData;
   wire        outLast;
   wire        outReady;
   reg         slow;
   wire        got;
   wire [8:0]  gotByte;
   logic [8:0] expQ[$];
   integer     fail_count = 0;
   integer     checks = 0;
   integer     seed = 81362;
   integer     cyc = 0;
   reg  [31:0] w;

   prf_framer DUT (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .outValid(outValid), .outData(outData), .outLast(outLast), .outReady(outReady));
   prf_sink_model sink (.clock(clock), .rst(rst), .slow(slow), .outValid(outValid),
      .outData(outData), .outLast(outLast), .outReady(outReady), .got(got), .gotByte(gotByte));

   // Clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task chk(input ok, input string m);
      checks = checks + 1;
      if (!ok) begin
         fail_count = fail_count + 1;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One APB transfer, holding the request until pready is sampled
   task apb(input [7:0] a, input wr, input [31:0] d, input [31:0] x, input e);
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      chk(pslverr === e, "apb error flag");
      if (!wr) chk(prdata === x, "apb read data");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input [7:0] a, input [31:0] d);
      apb(a, 1'b1, d, 32'h0, 1'b0);
   endtask

   // Queue the low n bytes of v, most significant first
   task push(input [31:0] v, input integer n);
      for (int i = n - 1; i >= 0; i--) expQ.push_back({1'b0, v[i*8 +: 8]});
   endtask

   // Store a word in report memory and queue its top n bytes
   task mw(input [31:0] v, input integer n);
      wr(8'h24, v);
      push(v >> (32 - 8 * n), n);
   endtask

   // Program header and fixed fields with random measurements
   task common(input [4:0] st, input [23:0] cnt);
      wr(8'h08, {8'h00, cnt});
      push({3'h0, st}, 1);
      push({cnt[7:0], cnt[15:8], cnt[23:16]}, 3);
      for (int k = 0; k < 4; k++) begin
         w = $random(seed);
         wr(8'h0C + 8'(k * 4), w);
         if (k == 2) push({w[7:0], w[15:8], w[31:16]}, 4);
         else push(w, 4);
      end
   endtask

   task run(input [4:0] st);
      expQ[expQ.size() - 1][8] = 1'b1;
      wr(8'h00, {23'h0, 1'b1, 3'h0, st});
   endtask

   task drain(input string n);
      while (expQ.size() > 0) @(posedge clock);
      repeat (4) @(posedge clock);
      $display("done %s", n);
   endtask

   // Compare each received byte with the oldest note, and cut hangs short
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (got) chk(expQ.size() > 0 && gotByte === expQ.pop_front(), "report byte");
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         close_out;
      end
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      apb(8'h04, 1'b0, 32'h0, 32'h0, 1'b0);
      apb(8'h40, 1'b0, 32'h0, 32'h0, 1'b1);
      apb(8'h02, 1'b0, 32'h0, 32'h0, 1'b1);
      $display("done apb");
      common(5'h12, 24'h000207);
      run(5'h12);
      drain("plain");
      common(5'h1D, 24'h0103FF);
      wr(8'h20, 32'h0);
      for (int k = 0; k < 3; k++) begin
         w = $random(seed);
         mw(w, 4);
      end
      w = $random(seed);
      mw(w, 3);
      wr(8'h24, 32'hF005A006);
      push(32'h00050006, 4);
      for (int k = 0; k < 2; k++) begin
         w = $random(seed);
         mw(w, 4);
      end
      w = $random(seed);
      wr(8'h1C, {w[31:8], 8'h05});
      push({w[31:8], 8'h05}, 4);
      w = $random(seed);
      mw(w, 4);
      w = $random(seed);
      mw(w, 1);
      slow <= 1'b1;
      run(5'h1D);
      apb(8'h08, 1'b1, 32'h0, 32'h0, 1'b1);
      drain("full");
      slow <= 1'b0;
      wr(8'h1C, 32'h00000021);
      wr(8'h00, 32'h00000101);
      apb(8'h04, 1'b0, 32'h0, 32'h00000202, 1'b0);
      wr(8'h04, 32'h00000002);
      apb(8'h04, 1'b0, 32'h0, 32'h00000200, 1'b0);
      repeat (30) @(posedge clock);
      $display("done refuse");
      close_out;
   end
endmodule

bind prf_framer prf_framer_checker chk (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .outValid(outValid), .outData(outData), .outLast(outLast),
   .outReady(outReady));
